// ===== logic/elu_regs.vh
/*
  Register offsets, field positions, reset values and timing constants of the
  event link interrupt unit.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef ELU_REGS_VH
`define ELU_REGS_VH

// ************************************************
// Word offsets (byte address = offset)
// ************************************************
`define ELU_SLOT_SEL_BASE  8'h00
`define ELU_PIN_CTL_BASE   8'h80
`define ELU_EXT_STAT       8'hA0
`define ELU_NMI_CTL        8'hA4
`define ELU_NMI_EN         8'hA8
`define ELU_NMI_STAT       8'hAC
`define ELU_NMI_CLR        8'hB0
`define ELU_WAKE_EN        8'hB4
`define ELU_SNZ_SEL        8'hB8
`define ELU_SLOT_STAT      8'hBC

// ************************************************
// Field positions
// ************************************************
`define ELU_SLOT_DTC_BIT   8
`define ELU_TRIG_LSB       0
`define ELU_FLT_EN_BIT     4
`define ELU_RATE_LSB       6
`define ELU_NMI_EDGE_BIT   0
`define ELU_NMI_FLT_BIT    1
`define ELU_NMI_RATE_LSB   2

// ************************************************
// Trigger and rate encodings
// ************************************************
`define ELU_TRIG_FALL      2'h0
`define ELU_TRIG_RISE      2'h1
`define ELU_TRIG_BOTH      2'h2
`define ELU_TRIG_LOW       2'h3
`define ELU_RATE_DIV1      2'h0
`define ELU_RATE_DIV8      2'h1
`define ELU_RATE_DIV32     2'h2
`define ELU_RATE_DIV64     2'h3

// ************************************************
// Reset values and timing
// ************************************************
`define ELU_RST_ZERO       32'h0000_0000
`define ELU_FLT_SAMPLES    3
`define ELU_DIV8_LAST      6'h07
`define ELU_DIV32_LAST     6'h1F
`define ELU_DIV64_LAST     6'h3F

`endif

// ===== logic/elu_event_link_unit.v
/*
  Event link interrupt unit: routes peripheral and external pin events to
  32 controller slots, gathers non-maskable sources and forms the wakeup
  request, with a classic Wishbone register slave.
  Assumes all inputs synchronous to clk_i and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "elu_regs.vh"

// What this block does
// [RULE_01] Route selected peripheral events to the interrupt and transfer controllers.
// [RULE_02] Each slot picks its source from event numbers 9 to 141; the code also accepts the pin event numbers 1 to 8.
// [RULE_03] Drive 32 interrupt lines, each from one selected event.
// [RULE_04] Eight external request pins, each an independent source.
// [RULE_05] Pins detect low level, falling, rising or both edges.
// [RULE_06] Exactly one detection method is active per pin at any time.
// [RULE_07] Optional digital noise filter ahead of each pin's trigger detection.
// [RULE_08] A slot may start the transfer controller instead of a CPU interrupt.
// [RULE_09] Non-maskable pin triggers on chosen edge, with optional filter.
// [RULE_10] Main oscillator stop raises a non-maskable interrupt.
// [RULE_11] Both watchdogs raise non-maskable interrupts on underflow or refresh error.
// [RULE_12] Voltage monitors one and two each raise their own non-maskable interrupt.
// [RULE_13] SRAM parity error raises a non-maskable interrupt.
// [RULE_14] SRAM ECC error raises a non-maskable interrupt.
// [RULE_15] Bus slave error raises a non-maskable interrupt.
// [RULE_16] Bus master error raises a non-maskable interrupt.
// [RULE_17] Stack pointer monitor violation raises a non-maskable interrupt.
// [RULE_18] In sleep any non-maskable or other interrupt wakes the device.
// [RULE_19] In standby only non-maskable or wakeup-enabled interrupts wake it.
// [RULE_20] In snooze only non-maskable or snooze-selected and wakeup-enabled interrupts wake.
// [RULE_21] Filter drops pulses shorter than three samples at the filter rate.
// [RULE_22] Filter rate per pin is clock divided by 1, 8, 32 or 64.
// [RULE_23] Trigger set in each pin's control register; one pin per number.
// [RULE_24] Each non-maskable source sets readable status; enable cannot be undone.
module elu_event_link_unit #(
  parameter NUM_SLOTS = 32,
  parameter NUM_PINS = 8,
  parameter EVT_MIN = 9,
  parameter EVT_MAX = 141,
  parameter NUM_NMI = 11
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [EVT_MAX:EVT_MIN] periph_evt_i,
  input wire [NUM_PINS-1:0] external_request_pins_i,
  input wire nmi_pin_i,
  input wire osc_stop_i,
  input wire window_watchdog_i,
  input wire independent_watchdog_i,
  input wire voltage_monitor_one_i,
  input wire voltage_monitor_two_i,
  input wire sram_parity_fault_i,
  input wire sram_ecc_fault_i,
  input wire bus_slave_fault_i,
  input wire bus_master_fault_i,
  input wire stack_monitor_fault_i,
  input wire [1:0] lp_mode_i,
  output wire [NUM_SLOTS-1:0] nested_vector_controller_irq_o,
  output wire [NUM_SLOTS-1:0] transfer_controller_req_o,
  output wire nmi_o,
  output wire wakeup_o
);

  localparam LP_RUN = 2'h0;
  localparam LP_SLEEP = 2'h1;
  localparam LP_STANDBY = 2'h2;
  localparam LP_SNOOZE = 2'h3;
  localparam NCH = NUM_PINS + 1;

  // ************************************************
  // Functions
  // ************************************************
  function [31:0] wb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      wb_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          wb_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  function rate_tick;
    input [1:0] rate;
    input [5:0] cnt;
    begin
      case (rate)
        `ELU_RATE_DIV1: rate_tick = 1'b1;
        `ELU_RATE_DIV8: rate_tick = (cnt[2:0] == `ELU_DIV8_LAST);
        `ELU_RATE_DIV32: rate_tick = (cnt[4:0] == `ELU_DIV32_LAST);
        default: rate_tick = (cnt == `ELU_DIV64_LAST);
      endcase
    end
  endfunction

  // ************************************************
  // State
  // ************************************************
  reg [8:0] slot_sel_q [0:NUM_SLOTS-1];
  reg [7:0] pin_ctl_q [0:NUM_PINS-1];
  reg [NUM_PINS-1:0] ext_stat_q;
  reg [3:0] nmi_ctl_q;
  reg [NUM_NMI-1:0] nmi_en_q;
  reg [NUM_NMI-1:0] nmi_stat_q;
  reg [NUM_SLOTS-1:0] wake_en_q;
  reg [4:0] snz_sel_q;
  reg [5:0] div_q;
  reg [2*NCH-1:0] smp_q;
  reg [NCH-1:0] filt_q;
  reg [NCH-1:0] prev_q;
  reg [NUM_SLOTS-1:0] irq_q;
  reg [NUM_SLOTS-1:0] dtc_q;
  reg nmi_q;
  reg wake_q;
  reg ack_q;
  reg [31:0] dat_q;

  wire [NCH-1:0] raw = {nmi_pin_i, external_request_pins_i};
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wb_wr = wb_req & wb_we_i;
  wire [5:0] word = wb_adr_i[7:2];
  wire hit_slot = (wb_adr_i < `ELU_PIN_CTL_BASE);
  wire hit_pin = ~hit_slot & (wb_adr_i < `ELU_EXT_STAT);

  // ************************************************
  // Write data with byte lanes applied
  // ************************************************
  // Merged at full bus width, then cut to each register's own width
  wire [31:0] wr_data_m = wb_merge(`ELU_RST_ZERO, wb_dat_i, wb_sel_i);
  wire [31:0] slot_m = wb_merge({23'h0, slot_sel_q[word[4:0]]}, wb_dat_i, wb_sel_i);
  wire [31:0] pin_m = wb_merge({24'h0, pin_ctl_q[word[2:0]]}, wb_dat_i, wb_sel_i);
  wire [31:0] nmi_ctl_m = wb_merge({28'h0, nmi_ctl_q}, wb_dat_i, wb_sel_i);
  wire [31:0] wake_en_m = wb_merge(wake_en_q, wb_dat_i, wb_sel_i);
  wire [31:0] snz_m = wb_merge({27'h0, snz_sel_q}, wb_dat_i, wb_sel_i);

  // ************************************************
  // Filter and trigger detection
  // ************************************************
  reg [NCH-1:0] cond;
  reg [NCH-1:0] tick;
  reg [NUM_PINS-1:0] ext_det;
  reg nmi_pin_det;
  integer c;
  always @* begin
    cond = {NCH{1'b0}};
    tick = {NCH{1'b0}};
    ext_det = {NUM_PINS{1'b0}};
    nmi_pin_det = 1'b0;
    for (c = 0; c < NCH; c = c + 1) begin
      if (c < NUM_PINS) begin
        tick[c] = rate_tick(pin_ctl_q[c][`ELU_RATE_LSB +: 2], div_q); // [RULE_22]
        // Filtered level when enabled, raw pin otherwise
        cond[c] = pin_ctl_q[c][`ELU_FLT_EN_BIT] ? filt_q[c] : raw[c]; // [RULE_07]
      end else begin
        tick[c] = rate_tick(nmi_ctl_q[`ELU_NMI_RATE_LSB +: 2], div_q);
        cond[c] = nmi_ctl_q[`ELU_NMI_FLT_BIT] ? filt_q[c] : raw[c];
      end
    end
    for (c = 0; c < NUM_PINS; c = c + 1) begin
      // A two-bit field selects exactly one method per pin
      case (pin_ctl_q[c][`ELU_TRIG_LSB +: 2]) // [RULE_05] [RULE_06] [RULE_23]
        `ELU_TRIG_FALL: ext_det[c] = prev_q[c] & ~cond[c];
        `ELU_TRIG_RISE: ext_det[c] = ~prev_q[c] & cond[c];
        `ELU_TRIG_BOTH: ext_det[c] = prev_q[c] ^ cond[c];
        default: ext_det[c] = ~cond[c];
      endcase
    end
    if (nmi_ctl_q[`ELU_NMI_EDGE_BIT]) begin // [RULE_09]
      nmi_pin_det = ~prev_q[NUM_PINS] & cond[NUM_PINS];
    end else begin
      nmi_pin_det = prev_q[NUM_PINS] & ~cond[NUM_PINS];
    end
  end

  // ************************************************
  // Event vector and slot selection
  // ************************************************
  // Numbers 1..8 carry the pin detections, 9..141 the peripherals
  wire [EVT_MAX:0] ev_all = {periph_evt_i, ext_det, 1'b0}; // [RULE_04]

  reg [NUM_SLOTS-1:0] slot_ev;
  integer s;
  always @* begin
    slot_ev = {NUM_SLOTS{1'b0}};
    for (s = 0; s < NUM_SLOTS; s = s + 1) begin
      // Out of range numbers select nothing
      if (slot_sel_q[s][7:0] != 8'h00 && slot_sel_q[s][7:0] <= EVT_MAX[7:0]) begin // [RULE_02]
        slot_ev[s] = ev_all[slot_sel_q[s][7:0]];
      end
    end
  end

  wire [NUM_NMI-1:0] nmi_src = {stack_monitor_fault_i, // [RULE_17]
                                bus_master_fault_i,    // [RULE_16]
                                bus_slave_fault_i,     // [RULE_15]
                                sram_ecc_fault_i,      // [RULE_14]
                                sram_parity_fault_i,   // [RULE_13]
                                voltage_monitor_two_i, // [RULE_12]
                                voltage_monitor_one_i, // [RULE_12]
                                independent_watchdog_i,// [RULE_11]
                                window_watchdog_i,     // [RULE_11]
                                osc_stop_i,            // [RULE_10]
                                nmi_pin_det};          // [RULE_09]

  // ************************************************
  // Wakeup decision
  // ************************************************
  wire [NUM_SLOTS-1:0] slot_any = slot_ev;
  wire nmi_any = |(nmi_stat_q & nmi_en_q);
  reg wake_d;
  always @* begin
    case (lp_mode_i)
      LP_SLEEP: wake_d = nmi_any | (|slot_any); // [RULE_18]
      LP_STANDBY: wake_d = nmi_any | (|(slot_any & wake_en_q)); // [RULE_19]
      LP_SNOOZE: wake_d = nmi_any | (slot_any[snz_sel_q] & wake_en_q[snz_sel_q]); // [RULE_20]
      default: wake_d = 1'b0;
    endcase
  end

  // ************************************************
  // Register read mux
  // ************************************************
  reg [31:0] rd_d;
  always @* begin
    rd_d = `ELU_RST_ZERO;
    if (hit_slot) begin
      rd_d[8:0] = slot_sel_q[word[4:0]];
    end else if (hit_pin) begin
      rd_d[7:0] = pin_ctl_q[word[2:0]];
    end else begin
      case ({word, 2'b00})
        `ELU_EXT_STAT: rd_d[NUM_PINS-1:0] = ext_stat_q;
        `ELU_NMI_CTL: rd_d[3:0] = nmi_ctl_q;
        `ELU_NMI_EN: rd_d[NUM_NMI-1:0] = nmi_en_q;
        `ELU_NMI_STAT: rd_d[NUM_NMI-1:0] = nmi_stat_q; // [RULE_24]
        `ELU_WAKE_EN: rd_d[NUM_SLOTS-1:0] = wake_en_q;
        `ELU_SNZ_SEL: rd_d[4:0] = snz_sel_q;
        `ELU_SLOT_STAT: rd_d[NUM_SLOTS-1:0] = irq_q | dtc_q;
        default: rd_d = `ELU_RST_ZERO;
      endcase
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < NUM_SLOTS; i = i + 1) begin
        slot_sel_q[i] <= 9'h000;
      end
      for (i = 0; i < NUM_PINS; i = i + 1) begin
        pin_ctl_q[i] <= 8'h00;
      end
      nmi_ctl_q <= 4'h0;
      nmi_en_q <= {NUM_NMI{1'b0}};
      wake_en_q <= {NUM_SLOTS{1'b0}};
      snz_sel_q <= 5'h00;
    end else begin
      if (wb_wr && hit_slot) begin
        slot_sel_q[word[4:0]] <= slot_m[8:0];
      end
      if (wb_wr && hit_pin) begin
        pin_ctl_q[word[2:0]] <= pin_m[7:0];
      end
      if (wb_wr && {word, 2'b00} == `ELU_NMI_CTL) begin
        nmi_ctl_q <= nmi_ctl_m[3:0];
      end
      if (wb_wr && {word, 2'b00} == `ELU_WAKE_EN) begin
        wake_en_q <= wake_en_m[NUM_SLOTS-1:0];
      end
      if (wb_wr && {word, 2'b00} == `ELU_SNZ_SEL) begin
        snz_sel_q <= snz_m[4:0];
      end
      // Enable bits can only be set, so software cannot mask a source later
      if (wb_wr && {word, 2'b00} == `ELU_NMI_EN) begin
        nmi_en_q <= nmi_en_q | wr_data_m[NUM_NMI-1:0]; // [RULE_24]
      end
    end
  end

  // ************************************************
  // Sample divider, filter and edge history
  // ************************************************
  integer j;
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 6'h00;
      smp_q <= {2*NCH{1'b0}};
      filt_q <= {NCH{1'b0}};
      prev_q <= {NCH{1'b0}};
    end else begin
      div_q <= div_q + 6'h01;
      prev_q <= cond;
      // Three agreeing samples needed before the filtered level moves
      for (j = 0; j < NCH; j = j + 1) begin
        if (tick[j]) begin
          smp_q[j*2 +: 2] <= {smp_q[j*2], raw[j]};
          if (smp_q[j*2 +: 2] == {2{raw[j]}}) begin // [RULE_21]
            filt_q[j] <= raw[j];
          end
        end
      end
    end
  end

  // ************************************************
  // Status flags
  // ************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_stat_q <= {NUM_PINS{1'b0}};
      nmi_stat_q <= {NUM_NMI{1'b0}};
    end else begin
      // Write one to clear; a fresh event in the same cycle wins
      if (wb_wr && {word, 2'b00} == `ELU_EXT_STAT) begin
        ext_stat_q <= (ext_stat_q & ~wr_data_m[NUM_PINS-1:0]) | ext_det;
      end else begin
        ext_stat_q <= ext_stat_q | ext_det;
      end
      if (wb_wr && {word, 2'b00} == `ELU_NMI_CLR) begin
        nmi_stat_q <= (nmi_stat_q & ~wr_data_m[NUM_NMI-1:0]) | nmi_src; // [RULE_24]
      end else begin
        nmi_stat_q <= nmi_stat_q | nmi_src;
      end
    end
  end

  // ************************************************
  // Registered outputs and bus answer
  // ************************************************
  integer k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= {NUM_SLOTS{1'b0}};
      dtc_q <= {NUM_SLOTS{1'b0}};
      nmi_q <= 1'b0;
      wake_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= `ELU_RST_ZERO;
    end else begin
      // A slot goes either to the CPU or to the transfer controller
      for (k = 0; k < NUM_SLOTS; k = k + 1) begin
        irq_q[k] <= slot_ev[k] & ~slot_sel_q[k][`ELU_SLOT_DTC_BIT]; // [RULE_01] [RULE_03]
        dtc_q[k] <= slot_ev[k] & slot_sel_q[k][`ELU_SLOT_DTC_BIT]; // [RULE_08]
      end
      nmi_q <= nmi_any;
      wake_q <= wake_d;
      // One answer per request; ack falls again even if strobe stays up
      ack_q <= wb_req;
      dat_q <= wb_req ? rd_d : `ELU_RST_ZERO;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign nested_vector_controller_irq_o = irq_q;
  assign transfer_controller_req_o = dtc_q;
  assign nmi_o = nmi_q;
  assign wakeup_o = wake_q;

endmodule

`default_nettype wire

// ===== test/elu_event_link_checker.sv
/*
  Checker of the event link unit: bus handshake, slot routing, nmi, wake.
  Assumes bind onto the unit's top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module elu_event_link_checker #(
  parameter NUM_SLOTS = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire osc_stop_i,
  input wire [1:0] lp_mode_i,
  input wire [NUM_SLOTS-1:0] nested_vector_controller_irq_o,
  input wire [NUM_SLOTS-1:0] transfer_controller_req_o,
  input wire nmi_o,
  input wire wakeup_o
);
  // ****
  // Enable mirror; set-only, so no clear path
  // ****
  logic req;
  logic clr;
  logic [31:0] msk;
  logic [31:0] en_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr = req && wb_we_i && wb_adr_i[7:2] == 6'h2C;
  assign msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  always @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 32'h0;
    end else if (req && wb_we_i && wb_adr_i[7:2] == 6'h2A) begin
      en_q <= en_q | (wb_dat_i & msk);
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_reads_zero: assert property (req && !wb_we_i && wb_adr_i >= 8'hC0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_route_one_side: assert property ((nested_vector_controller_irq_o & transfer_controller_req_o) == '0)
    else $error("slot on both outputs");
  a_nmi_osc_raise: assert property (osc_stop_i && en_q[1] |-> ##2 nmi_o)
    else $error("oscillator stop did not raise nmi");
  a_nmi_holds_set: assert property (nmi_o && !$past(clr) |=> nmi_o)
    else $error("nmi dropped without clear");
  a_wake_on_nmi: assert property (nmi_o && $past(lp_mode_i) != 2'h0 |-> wakeup_o)
    else $error("nmi did not wake");
endmodule
`default_nettype wire

// ===== test/elu_far_side_model.sv
/*
  Far side model: interrupt and transfer controllers count new slot requests.
  Assumes registered level slot outputs of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module elu_far_side_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] irq_i,
  input wire logic [31:0] dtc_i,
  output var int irq_seen_o,
  output var int dtc_seen_o
);
  logic [31:0] irq_q;
  logic [31:0] dtc_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_seen_o <= 0;
      dtc_seen_o <= 0;
      irq_q <= 32'h0;
      dtc_q <= 32'h0;
    end else begin
      irq_seen_o <= irq_seen_o + $countones(irq_i & ~irq_q);
      dtc_seen_o <= dtc_seen_o + $countones(dtc_i & ~dtc_q);
      irq_q <= irq_i;
      dtc_q <= dtc_i;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
  Testbench of the event link unit: random slot routing, pin triggers, filter,
  nmi sources, wake decisions, over a classic Wishbone master.
  Assumes the design header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "elu_regs.vh"
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi_pin = 1'b0;
  logic [7:0] adr = 8'h00, pins = 8'h00;
  logic [31:0] wdat = 32'h0, rd, lfsr_q = 32'h231a;
  logic [141:9] evt = '0;
  logic [1:0] mode = 2'h0;
  logic [9:0] src = 10'h0;
  logic [3:0] x;
  logic [7:0] rst_adr [5] = '{8'h00, 8'h80, 8'hA8, 8'hAC, 8'hB4};
  wire [31:0] dat_o, irq, transfer_controller;
  wire ack, nmi, wake;
  int fail_count = 0, compares = 0, cycles = 0, irq_seen, dtc_seen, exp_irq = 0, exp_dtc = 0, s, e;
  always #5 clk_i = ~clk_i;
  elu_event_link_unit u_elu_event_link_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .periph_evt_i(evt), .external_request_pins_i(pins), .nmi_pin_i(nmi_pin), .osc_stop_i(src[0]),
    .window_watchdog_i(src[1]), .independent_watchdog_i(src[2]), .voltage_monitor_one_i(src[3]),
    .voltage_monitor_two_i(src[4]), .sram_parity_fault_i(src[5]), .sram_ecc_fault_i(src[6]),
    .bus_slave_fault_i(src[7]), .bus_master_fault_i(src[8]), .stack_monitor_fault_i(src[9]),
    .lp_mode_i(mode), .nested_vector_controller_irq_o(irq), .transfer_controller_req_o(transfer_controller),
    .nmi_o(nmi), .wakeup_o(wake));
  elu_far_side_model u_elu_far_side_model (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .dtc_i(transfer_controller),
    .irq_seen_o(irq_seen), .dtc_seen_o(dtc_seen));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic pin_hit(input logic [1:0] t, input logic rising);
    return rising ? (t != `ELU_TRIG_FALL) : (t != `ELU_TRIG_RISE);
  endfunction
  function automatic logic wake_exp(input logic [1:0] m, input logic en, input logic sz);
    return (m == 2'h1) || (m == 2'h2 && en) || (m == 2'h3 && en && !sz);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short; the whole run needs about a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_adr[i]) begin
      bus(1'b0, rst_adr[i], 32'h0);
      check(rd, `ELU_RST_ZERO);
    end
    bus(1'b1, 8'hC0, 32'hFFFFFFFF);
    bus(1'b0, 8'hC0, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 8; k++) begin
      lfsr_q = lfsr(lfsr_q);
      s = k * 4 + lfsr_q[1:0];
      e = (k == 0) ? 9 : (k == 7) ? 141 : 9 + lfsr_q[15:8] % 133;
      bus(1'b1, 8'(s * 4), {23'h0, lfsr_q[4], 8'(e)});
      evt[e] <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(irq, lfsr_q[4] ? 32'h0 : 32'h1 << s);
      check(transfer_controller, lfsr_q[4] ? 32'h1 << s : 32'h0);
      bus(1'b0, 8'hBC, 32'h0);
      check(rd, 32'h1 << s);
      exp_dtc += lfsr_q[4];
      exp_irq += !lfsr_q[4];
      evt[e] <= 1'b0;
      bus(1'b1, 8'(s * 4), 32'h0);
    end
    check(irq_seen, exp_irq);
    check(dtc_seen, exp_dtc);
    for (int p = 0; p < 8; p++) bus(1'b1, 8'h80 + 8'(p * 4), p < 4 ? 32'(p) : {24'h0, 2'(p - 4), 6'h12});
    bus(1'b1, 8'h08, 32'h3);
    e = irq_seen;
    for (int r = 0; r < 2; r++) begin
      pins[3:0] <= {4{~r[0]}};
      repeat (4) @(posedge clk_i);
      bus(1'b1, 8'hA0, 32'hFF);
      pins[3:0] <= {4{r[0]}};
      repeat (4) @(posedge clk_i);
      bus(1'b0, 8'hA0, 32'h0);
      for (int p = 0; p < 4; p++) x[p] = pin_hit(2'(p), r[0]);
      check(rd & 32'hF, {28'h0, x});
    end
    check(irq_seen, e + 3);
    bus(1'b1, 8'hA0, 32'hFF);
    pins[7:4] <= 4'hF;
    repeat (2) @(posedge clk_i);
    pins[7:4] <= 4'h0;
    repeat (200) @(posedge clk_i);
    bus(1'b0, 8'hA0, 32'h0);
    check(rd & 32'hF0, 32'h0);
    pins[7:4] <= 4'hF;
    repeat (260) @(posedge clk_i);
    bus(1'b0, 8'hA0, 32'h0);
    check(rd & 32'hF0, 32'hF0);
    bus(1'b1, 8'hA8, 32'h7FF);
    bus(1'b1, 8'hA8, 32'h0);
    bus(1'b0, 8'hA8, 32'h0);
    check(rd, 32'h7FF);
    for (int i = 0; i < 10; i++) begin
      src[i] <= 1'b1;
      @(posedge clk_i);
      src[i] <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(32'(nmi), 32'h1);
      bus(1'b0, 8'hAC, 32'h0);
      check(rd, 32'h2 << i);
      bus(1'b1, 8'hB0, 32'h2 << i);
      bus(1'b0, 8'hAC, 32'h0);
      check(rd, 32'h0);
    end
    for (int r = 1; r >= 0; r--) begin
      bus(1'b1, 8'hA4, 32'(r));
      bus(1'b1, 8'hB0, 32'h1);
      nmi_pin <= r[0];
      repeat (4) @(posedge clk_i);
      bus(1'b0, 8'hAC, 32'h0);
      check(rd, 32'h1);
    end
    bus(1'b1, 8'hA4, 32'h2);
    bus(1'b1, 8'hB0, 32'h1);
    for (int w = 2; w < 9; w += 6) begin
      nmi_pin <= 1'b1;
      repeat (w) @(posedge clk_i);
      nmi_pin <= 1'b0;
      repeat (6) @(posedge clk_i);
      bus(1'b0, 8'hAC, 32'h0);
      check(rd, 32'(w > 2));
    end
    bus(1'b1, 8'hB0, 32'h1);
    bus(1'b1, 8'h00, 32'h9);
    evt[9] <= 1'b1;
    for (int m = 0; m < 4; m++) for (int c = 0; c < 4; c++) begin
      lfsr_q = lfsr(lfsr_q);
      bus(1'b1, 8'hB4, {lfsr_q[31:1], c[0]});
      bus(1'b1, 8'hB8, {27'h0, c[1] ? lfsr_q[4:0] | 5'h1 : 5'h0});
      mode <= 2'(m);
      repeat (3) @(posedge clk_i);
      check(32'(wake), 32'(wake_exp(2'(m), c[0], c[1])));
    end
    src[0] <= 1'b1;
    @(posedge clk_i);
    src[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(32'(wake), 32'h1);
    complete_run();
  end
endmodule
bind elu_event_link_unit elu_event_link_checker #(.NUM_SLOTS(NUM_SLOTS)) u_elu_event_link_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .osc_stop_i(osc_stop_i), .lp_mode_i(lp_mode_i), .nested_vector_controller_irq_o(nested_vector_controller_irq_o),
  .transfer_controller_req_o(transfer_controller_req_o), .nmi_o(nmi_o), .wakeup_o(wakeup_o));
`default_nettype wire
